// ===== hdl/dbm_top.sv
/*
 * Control logic of a dual full-bridge motor driver: decodes the four host inputs into
 * terminal drive states, with per-bridge overcurrent guards, thermal shutdown with
 * hysteresis, undervoltage lockout and idle sleep.
 * Assumes all inputs are asynchronous pins from the host or analog comparators; the
 * thermal comparator reports the hysteresis itself via a separate recovery flag.
 */
`timescale 1ns/1ps

// What this block does
// RQ1: Each bridge drives forward on 1,0, reverse on 0,1, both sinks on 1,1 and off on 0,0.
// RQ2: Fast and slow decay under external PWM come from the host alternating with 0,0 or 1,1.
// RQ3: The host steps a stepper through the full-step or eight-code half-step sequences.
// RQ4: For paralleled operation the host drives both bridges with identical codes.
// RQ5: All four inputs low for longer than the standby delay puts the block to sleep, outputs off.
// RQ6: Source current above the limit for longer than the filter time raises a fault.
// RQ7: Sink drain-source voltage above threshold for longer than the filter time raises a fault.
// RQ8: A fault turns off both halves of the affected bridge only.
// RQ9: After a fault the bridge ignores its commands for the blanking period, then retries.
// RQ10: Each bridge has its own fault detection, disable and retry state.
// RQ11: Over-temperature disables all outputs until the temperature falls by the hysteresis.
// RQ12: While undervoltage is flagged all outputs stay off regardless of inputs.
// RQ13: Any input going high wakes the block and normal decoding resumes.
module dbm_top
	import dbm_pkg::*;
#(
	parameter int unsigned IDLE_CYC  = dbm_pkg::IDLE_SLEEP_CYC,
	parameter int unsigned FILT_CYC  = dbm_pkg::FILTER_CYC,
	parameter int unsigned BLNK_CYC  = dbm_pkg::BLANK_CYC
) (
	input  wire logic              clock,             // 25 MHz clock
	input  wire logic              reset_n,           // async active-low reset
	input  wire logic              bridge_a_ctrl_p,   // bridge A input, positive
	input  wire logic              bridge_a_ctrl_n,   // bridge A input, negative
	input  wire logic              bridge_b_ctrl_p,   // bridge B input, positive
	input  wire logic              bridge_b_ctrl_n,   // bridge B input, negative
	input  wire logic              a_src_over,        // bridge A source overcurrent
	input  wire logic              a_snk_over,        // bridge A sink Vds over threshold
	input  wire logic              b_src_over,        // bridge B source overcurrent
	input  wire logic              b_snk_over,        // bridge B sink Vds over threshold
	input  wire logic              overheat_trip,     // die reached overheat_trip_point
	input  wire logic              overheat_clear,    // die below trip minus hysteresis
	input  wire logic              supply_low,        // supply undervoltage flag
	output dbm_pkg::dbm_drive_e    bridge_a_term_p,   // terminal drive A+
	output dbm_pkg::dbm_drive_e    bridge_a_term_n,   // terminal drive A-
	output dbm_pkg::dbm_drive_e    bridge_b_term_p,   // terminal drive B+
	output dbm_pkg::dbm_drive_e    bridge_b_term_n,   // terminal drive B-
	output logic                   asleep,            // sleep state, circuitry off
	output logic                   a_fault,           // bridge A blanked after fault
	output logic                   b_fault,           // bridge B blanked after fault
	output logic                   overheat           // thermal shutdown active
);
	import dbm_pkg::*;

	localparam int NIN = 11;

	typedef struct packed {
		logic [CNT_W-1:0] idle_cnt;
		logic             sleep;
		logic             hot;
		dbm_drive_e       a_p;
		dbm_drive_e       a_n;
		dbm_drive_e       b_p;
		dbm_drive_e       b_n;
		logic             a_flt;
		logic             b_flt;
	} dbm_top_s;

	dbm_top_s       st_ff;
	dbm_top_s       nxt_st;
	logic [1:0]     rst_sync_ff;
	logic           rst_n;
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] syn;
	logic [1:0]     code_a;
	logic [1:0]     code_b;
	logic           a_blank;
	logic           b_blank;
	logic           a_src_on;
	logic           b_src_on;
	logic           any_high;
	logic           kill_all;

	// The reset flops stay outside the state struct because they alone run on the raw
	// reset; sharing one variable between two reset domains would give it two drivers.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_ff <= '0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	assign raw_in = {bridge_a_ctrl_p, bridge_a_ctrl_n, bridge_b_ctrl_p, bridge_b_ctrl_n,
		a_src_over, a_snk_over, b_src_over, b_snk_over,
		overheat_trip, overheat_clear, supply_low};

	dbm_sync #(
		.W (NIN)
	) u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     (raw_in),
		.q     (syn)
	);

	assign code_a   = syn[10:9];
	assign code_b   = syn[8:7];
	assign any_high = |syn[10:7];
	// Source monitoring only matters once the driver is actually on.
	assign a_src_on = (st_ff.a_p == DBM_HIGH) || (st_ff.a_n == DBM_HIGH);  // [RQ6]
	assign b_src_on = (st_ff.b_p == DBM_HIGH) || (st_ff.b_n == DBM_HIGH);  // [RQ6]

	// One guard per bridge keeps fault state fully independent. [RQ10]
	dbm_guard #(
		.FILTER (FILT_CYC),
		.BLANK  (BLNK_CYC)
	) u_guard_a (
		.clock    (clock),
		.rst_n    (rst_n),
		.src_on   (a_src_on),
		.src_over (syn[6]),
		.snk_over (syn[5]),
		.blanked  (a_blank)
	);

	dbm_guard #(
		.FILTER (FILT_CYC),
		.BLANK  (BLNK_CYC)
	) u_guard_b (
		.clock    (clock),
		.rst_n    (rst_n),
		.src_on   (b_src_on),
		.src_over (syn[4]),
		.snk_over (syn[3]),
		.blanked  (b_blank)
	);

	function automatic logic [3:0] decode(input logic [1:0] code);
		logic [3:0] r;
		r = {DBM_OFF, DBM_OFF};
		case (code)
			CODE_FORWARD: r = {DBM_HIGH, DBM_LOW};  // [RQ1]
			CODE_REVERSE: r = {DBM_LOW, DBM_HIGH};  // [RQ1]
			CODE_BRAKE:   r = {DBM_LOW, DBM_LOW};   // [RQ1] [RQ2]
			CODE_COAST:   r = {DBM_OFF, DBM_OFF};   // [RQ1] [RQ2]
			default:      r = {DBM_OFF, DBM_OFF};
		endcase
		return r;
	endfunction : decode

	always_comb begin
		logic [3:0] da;
		logic [3:0] db;
		da     = decode(code_a);  // [RQ4]
		db     = decode(code_b);  // [RQ4]
		nxt_st = st_ff;

		// Idle timer: counts while all inputs are low, waking on any high input.
		if (any_high) begin
			nxt_st.idle_cnt = '0;
			nxt_st.sleep    = 1'b0;  // [RQ13]
		end else if (!st_ff.sleep) begin
			if (st_ff.idle_cnt == CNT_W'(IDLE_CYC)) begin
				nxt_st.sleep    = 1'b1;  // [RQ5]
				nxt_st.idle_cnt = '0;
			end else begin
				nxt_st.idle_cnt = st_ff.idle_cnt + 1'b1;
			end
		end

		// Trip wins over recovery so a hot die never re-enables.
		if (syn[2]) begin
			nxt_st.hot = 1'b1;  // [RQ11]
		end else if (syn[1]) begin
			nxt_st.hot = 1'b0;  // [RQ11]
		end

		kill_all = st_ff.sleep || st_ff.hot || syn[0] || syn[2];  // [RQ5] [RQ11] [RQ12]

		if (kill_all || a_blank) begin
			nxt_st.a_p = DBM_OFF;  // [RQ8] [RQ9]
			nxt_st.a_n = DBM_OFF;
		end else begin
			nxt_st.a_p = dbm_drive_e'(da[3:2]);
			nxt_st.a_n = dbm_drive_e'(da[1:0]);
		end
		if (kill_all || b_blank) begin
			nxt_st.b_p = DBM_OFF;  // [RQ8] [RQ9]
			nxt_st.b_n = DBM_OFF;
		end else begin
			nxt_st.b_p = dbm_drive_e'(db[3:2]);
			nxt_st.b_n = dbm_drive_e'(db[1:0]);
		end
		nxt_st.a_flt = a_blank;
		nxt_st.b_flt = b_blank;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff.idle_cnt <= '0;
			st_ff.sleep    <= 1'b0;
			st_ff.hot      <= 1'b0;
			st_ff.a_p      <= DBM_OFF;
			st_ff.a_n      <= DBM_OFF;
			st_ff.b_p      <= DBM_OFF;
			st_ff.b_n      <= DBM_OFF;
			st_ff.a_flt    <= 1'b0;
			st_ff.b_flt    <= 1'b0;
		end else begin
			st_ff.idle_cnt <= nxt_st.idle_cnt;
			st_ff.sleep    <= nxt_st.sleep;
			st_ff.hot      <= nxt_st.hot;
			st_ff.a_p      <= nxt_st.a_p;
			st_ff.a_n      <= nxt_st.a_n;
			st_ff.b_p      <= nxt_st.b_p;
			st_ff.b_n      <= nxt_st.b_n;
			st_ff.a_flt    <= nxt_st.a_flt;
			st_ff.b_flt    <= nxt_st.b_flt;
		end
	end

	assign bridge_a_term_p = st_ff.a_p;
	assign bridge_a_term_n = st_ff.a_n;
	assign bridge_b_term_p = st_ff.b_p;
	assign bridge_b_term_n = st_ff.b_n;
	assign asleep          = st_ff.sleep;
	assign a_fault         = st_ff.a_flt;
	assign b_fault         = st_ff.b_flt;
	assign overheat        = st_ff.hot;
endmodule : dbm_top

// ===== hdl/dbm_pkg.sv
/*
 * Package for the dual-bridge motor control logic: timing constants, drive codes and the
 * per-terminal drive state encoding.
 * Assumes a 25 MHz system clock; all delays are derived from it here.
 */
package dbm_pkg;
	localparam int unsigned CLK_HZ              = 25_000_000;
	// Times in their own units as specified.
	localparam int unsigned IDLE_SLEEP_DELAY_US = 1000;  // 1 ms standby interval
	localparam int unsigned FILTER_TIME_NS      = 2000;  // 2 us overcurrent filter
	localparam int unsigned BLANK_TIME_US       = 2000;  // 2 ms retry blanking
	// Derived cycle counts: least times round up.
	localparam int unsigned IDLE_SLEEP_CYC =
		(IDLE_SLEEP_DELAY_US * (CLK_HZ / 1_000_000));
	localparam int unsigned FILTER_CYC     =
		(FILTER_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned BLANK_CYC      =
		(BLANK_TIME_US * (CLK_HZ / 1_000_000));
	localparam int unsigned CNT_W          = 16;

	// Drive state of one terminal: source on, sink on, or off.
	typedef enum logic [1:0] {
		DBM_OFF,
		DBM_HIGH,
		DBM_LOW
	} dbm_drive_e;

	// Input pair codes {ctrl_p, ctrl_n}.
	localparam logic [1:0] CODE_COAST   = 2'h0;
	localparam logic [1:0] CODE_REVERSE = 2'h1;
	localparam logic [1:0] CODE_FORWARD = 2'h2;
	localparam logic [1:0] CODE_BRAKE   = 2'h3;
endpackage : dbm_pkg

// ===== hdl/dbm_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous inputs.
 * Assumes the inputs are quasi-static levels; the first stage feeds only the second.
 */
`timescale 1ns/1ps
module dbm_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,   // system clock
	input  wire logic         rst_n,   // synchronised reset
	input  wire logic [W-1:0] d,       // asynchronous input
	output logic      [W-1:0] q        // synchronised output
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} dbm_sync_s;

	dbm_sync_s st_ff;
	dbm_sync_s nxt_st;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.meta = d;
		nxt_st.sync = st_ff.meta;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.sync;
endmodule : dbm_sync

// ===== hdl/dbm_guard.sv
/*
 * Per-bridge overcurrent guard: filters the source and sink fault comparators, then
 * holds the bridge off for the blanking period before allowing a retry.
 * Assumes comparator inputs are already synchronised to the clock.
 */
`timescale 1ns/1ps
module dbm_guard
	import dbm_pkg::*;
#(
	parameter int unsigned FILTER = dbm_pkg::FILTER_CYC,
	parameter int unsigned BLANK  = dbm_pkg::BLANK_CYC
) (
	input  wire logic clock,     // system clock
	input  wire logic rst_n,     // synchronised reset
	input  wire logic src_on,    // a source driver of this bridge is on
	input  wire logic src_over,  // source current above limit
	input  wire logic snk_over,  // sink drain-source voltage above threshold
	output logic      blanked    // bridge held off, commands ignored
);
	typedef struct packed {
		logic [dbm_pkg::CNT_W-1:0] filt;
		logic [dbm_pkg::CNT_W-1:0] blank;
		logic                      active;
	} dbm_guard_s;

	dbm_guard_s st_ff;
	dbm_guard_s nxt_st;
	logic       over;

	always_comb begin
		over   = (src_on && src_over) || snk_over;  // [RQ6] [RQ7]
		nxt_st = st_ff;
		if (st_ff.active) begin
			nxt_st.filt = '0;
			if (st_ff.blank == dbm_pkg::CNT_W'(BLANK - 1)) begin
				nxt_st.active = 1'b0;  // [RQ9]
				nxt_st.blank  = '0;
			end else begin
				nxt_st.blank = st_ff.blank + 1'b1;
			end
		end else if (over) begin
			if (st_ff.filt == dbm_pkg::CNT_W'(FILTER - 1)) begin
				nxt_st.active = 1'b1;  // [RQ6] [RQ7] [RQ8]
				nxt_st.filt   = '0;
			end else begin
				nxt_st.filt = st_ff.filt + 1'b1;
			end
		end else begin
			nxt_st.filt = '0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign blanked = st_ff.active;
endmodule : dbm_guard

// ===== testbench/dbm_top_asserts.sv
/*
 * Checker for the dual-bridge control top: decode, protection and sleep timing.
 * Assumes it is bound to dbm_top and sees only its ports.
 */
`timescale 1ns/1ps
module dbm_top_asserts
	import dbm_pkg::*;
#(
	parameter int unsigned IDLE_CYC = dbm_pkg::IDLE_SLEEP_CYC,
	parameter int unsigned FILT_CYC = dbm_pkg::FILTER_CYC,
	parameter int unsigned BLNK_CYC = dbm_pkg::BLANK_CYC
) (
	input wire logic                clock,           // clock
	input wire logic                reset_n,         // reset
	input wire logic                bridge_a_ctrl_p, // pin
	input wire logic                bridge_a_ctrl_n, // pin
	input wire logic                bridge_b_ctrl_p, // pin
	input wire logic                bridge_b_ctrl_n, // pin
	input wire logic                a_src_over,      // flag
	input wire logic                a_snk_over,      // flag
	input wire logic                b_src_over,      // flag
	input wire logic                b_snk_over,      // flag
	input wire logic                overheat_trip,   // flag
	input wire logic                overheat_clear,  // flag
	input wire logic                supply_low,      // flag
	input wire dbm_pkg::dbm_drive_e bridge_a_term_p, // drive
	input wire dbm_pkg::dbm_drive_e bridge_a_term_n, // drive
	input wire dbm_pkg::dbm_drive_e bridge_b_term_p, // drive
	input wire dbm_pkg::dbm_drive_e bridge_b_term_n, // drive
	input wire logic                asleep,          // state
	input wire logic                a_fault,         // state
	input wire logic                b_fault,         // state
	input wire logic                overheat         // state
);
	localparam int unsigned IDLE_LIM = IDLE_CYC + 8;
	logic [7:0]  ha, hb;
	logic [5:0]  qa, qb;
	logic [3:0]  sl, oh, oc;
	logic [15:0] idle_cnt, bcnt;
	logic [3:0]  ta, tb_;
	assign ta  = {bridge_a_term_p, bridge_a_term_n};
	assign tb_ = {bridge_b_term_p, bridge_b_term_n};
	function automatic logic [3:0] dec(input logic [1:0] c);
		case (c)
			2'h2: dec = {DBM_HIGH, DBM_LOW};
			2'h1: dec = {DBM_LOW, DBM_HIGH};
			2'h3: dec = {DBM_LOW, DBM_LOW};
			default: dec = {DBM_OFF, DBM_OFF};
		endcase
	endfunction : dec
	// Histories let each check wait out the synchroniser without guessing its exact phase.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			{ha, hb, qa, qb, sl, oh, oc, idle_cnt, bcnt} <= '0;
		end else begin
			ha <= {ha[5:0], bridge_a_ctrl_p, bridge_a_ctrl_n};
			hb <= {hb[5:0], bridge_b_ctrl_p, bridge_b_ctrl_n};
			qa <= {qa[4:0], !(supply_low | overheat_trip | a_src_over | a_snk_over)};
			qb <= {qb[4:0], !(supply_low | overheat_trip | b_src_over | b_snk_over)};
			sl <= {sl[2:0], supply_low};
			oh <= {oh[2:0], overheat_trip};
			oc <= {oc[2:0], overheat_clear};
			if (bridge_a_ctrl_p | bridge_a_ctrl_n | bridge_b_ctrl_p | bridge_b_ctrl_n)
				idle_cnt <= '0;
			else if (idle_cnt < 16'(IDLE_LIM))
				idle_cnt <= idle_cnt + 16'h0001;
			bcnt <= a_fault ? bcnt + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	bridge_a_dec_a: assert property (ha[7:6] == ha[5:4] && qa == 6'h3f && !asleep && !$past(asleep)
		&& !a_fault && !$past(a_fault) && !overheat && !$past(overheat) |-> ta == dec(ha[5:4]))
		else $error("bridge A decode wrong");
	bridge_b_dec_a: assert property (hb[7:6] == hb[5:4] && qb == 6'h3f && !asleep && !$past(asleep)
		&& !b_fault && !$past(b_fault) && !overheat && !$past(overheat) |-> tb_ == dec(hb[5:4]))
		else $error("bridge B decode wrong");
	uvlo_off_a: assert property (sl == 4'hf |-> ta == 4'h0 && tb_ == 4'h0)
		else $error("output on in undervoltage");
	heat_trip_a: assert property (oh == 4'hf |-> overheat && ta == 4'h0 && tb_ == 4'h0)
		else $error("no thermal shutdown");
	heat_hold_a: assert property (overheat && oc == 4'h0 |=> overheat)
		else $error("thermal shutdown left early");
	sleep_off_a: assert property (asleep |-> ta == 4'h0 && tb_ == 4'h0)
		else $error("output on while asleep");
	sleep_entry_a: assert property (idle_cnt == 16'(IDLE_LIM) |-> asleep)
		else $error("sleep not entered");
	wake_up_a: assert property ((|ha[5:4] || |hb[5:4]) && (|ha[7:6] || |hb[7:6]) |-> !asleep)
		else $error("no wake on input");
	fault_off_a: assert property ($rose(a_fault) |-> (ta == 4'h0) [*8])
		else $error("faulted bridge driven");
	blank_len_a: assert property ($fell(a_fault) |-> bcnt >= 16'(BLNK_CYC - 1)
		&& bcnt <= 16'(BLNK_CYC + 2)) else $error("blanking length wrong");
endmodule : dbm_top_asserts

bind dbm_top dbm_top_asserts #(.IDLE_CYC(IDLE_CYC), .FILT_CYC(FILT_CYC), .BLNK_CYC(BLNK_CYC))
	i_dbm_top_asserts (.*);

// ===== testbench/dbm_host.sv
/*
 * Host controller model: drives the four control pins from a direct code or a step table.
 * Assumes the bench changes its inputs just after a clock edge.
 */
`timescale 1ns/1ps
module dbm_host (
	input  wire logic       seq_en, // step table drives the pins
	input  wire logic [2:0] step,   // half-step index
	input  wire logic [3:0] code,   // direct code
	output logic      [3:0] pins    // {a_p, a_n, b_p, b_n}
);
	// Even entries alone form the full-step cycle.
	localparam logic [31:0] STEPS = 32'hA264_5198;
	assign pins = seq_en ? STEPS[31 - 4 * step -: 4] : code;
endmodule : dbm_host

// ===== testbench/dbm_top_tb_top.sv
/*
 * Self-checking bench for the dual-bridge control top with a host model on its pins.
 * Assumes shortened timer parameters so the run stays brief.
 */
`timescale 1ns/1ps
module dbm_top_tb_top;
	import dbm_pkg::*;
	localparam int unsigned IDLE = 20;
	localparam int unsigned FILT = 3;
	localparam int unsigned BLNK = 30;
	logic       clock, reset_n, seq_en, a_src_over, a_snk_over, b_src_over, b_snk_over;
	logic       overheat_trip, overheat_clear, supply_low, asleep, a_fault, b_fault, overheat;
	logic [2:0] step;
	logic [3:0] code, pins;
	logic [7:0] terms;
	dbm_drive_e a_p, a_n, b_p, b_n;
	int         miscompares, samples_checked, cycles;
	assign terms = {a_p, a_n, b_p, b_n};
	dbm_host i_dbm_host (.seq_en(seq_en), .step(step), .code(code), .pins(pins));
	dbm_top #(.IDLE_CYC(IDLE), .FILT_CYC(FILT), .BLNK_CYC(BLNK)) i_dbm_top (
		.clock(clock), .reset_n(reset_n), .bridge_a_ctrl_p(pins[3]), .bridge_a_ctrl_n(pins[2]),
		.bridge_b_ctrl_p(pins[1]), .bridge_b_ctrl_n(pins[0]), .a_src_over(a_src_over),
		.a_snk_over(a_snk_over), .b_src_over(b_src_over), .b_snk_over(b_snk_over),
		.overheat_trip(overheat_trip), .overheat_clear(overheat_clear), .supply_low(supply_low),
		.bridge_a_term_p(a_p), .bridge_a_term_n(a_n), .bridge_b_term_p(b_p),
		.bridge_b_term_n(b_n), .asleep(asleep), .a_fault(a_fault), .b_fault(b_fault),
		.overheat(overheat));
	function automatic logic [3:0] dec(input logic [1:0] c);
		case (c)
			2'h2: dec = {DBM_HIGH, DBM_LOW};
			2'h1: dec = {DBM_LOW, DBM_HIGH};
			2'h3: dec = {DBM_LOW, DBM_LOW};
			default: dec = {DBM_OFF, DBM_OFF};
		endcase
	endfunction : dec
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask : chk
	task automatic summarize;
		$display("compares %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task automatic t_pwm;
		logic [1:0] seq [8];
		seq = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h1, 2'h3};
		for (int i = 0; i < 8; i++) begin
			code = {seq[i], seq[i]};
			cyc(5);
			chk(terms, {dec(seq[i]), dec(seq[i])});
		end
	endtask : t_pwm
	task automatic t_step;
		logic [3:0] hs [8];
		hs = '{4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9, 4'h8};
		seq_en = 1'b1;
		for (int i = 0; i < 8; i++) begin
			step = 3'(i);
			cyc(5);
			chk(terms, {dec(hs[i][3:2]), dec(hs[i][1:0])});
		end
		seq_en = 1'b0;
	endtask : t_step
	task automatic t_sleep;
		code = 4'h0;
		cyc(IDLE + 10);
		chk({7'h0, asleep}, 8'h01);
		code = 4'h1;
		cyc(6);
		chk({7'h0, asleep}, 8'h00);
		chk(terms, {dec(2'h0), dec(2'h1)});
	endtask : t_sleep
	task automatic t_fault;
		code = 4'hA;
		cyc(5);
		a_src_over = 1'b1;
		cyc(2);
		a_src_over = 1'b0;
		cyc(6);
		chk({7'h0, a_fault}, 8'h00);
		a_src_over = 1'b1;
		cyc(FILT + 6);
		a_src_over = 1'b0;
		chk({6'h0, a_fault, b_fault}, 8'h02);
		chk(terms, {4'h0, dec(2'h2)});
		cyc(10);
		chk({7'h0, a_fault}, 8'h01);
		cyc(BLNK + 5);
		chk(terms, {dec(2'h2), dec(2'h2)});
		b_snk_over = 1'b1;
		cyc(FILT + 6);
		b_snk_over = 1'b0;
		chk({6'h0, a_fault, b_fault}, 8'h01);
		cyc(BLNK + 10);
	endtask : t_fault
	task automatic t_protect;
		overheat_trip = 1'b1;
		cyc(5);
		overheat_trip = 1'b0;
		chk({7'h0, overheat}, 8'h01);
		chk(terms, 8'h00);
		cyc(5);
		chk({7'h0, overheat}, 8'h01);
		overheat_clear = 1'b1;
		cyc(6);
		overheat_clear = 1'b0;
		chk({7'h0, overheat}, 8'h00);
		chk(terms, {dec(2'h2), dec(2'h2)});
		supply_low = 1'b1;
		cyc(5);
		chk(terms, 8'h00);
		supply_low = 1'b0;
		cyc(6);
		chk(terms, {dec(2'h2), dec(2'h2)});
	endtask : t_protect
	initial clock = 1'b0;
	always #20 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		{reset_n, seq_en, a_src_over, a_snk_over, b_src_over, b_snk_over} = '0;
		{overheat_trip, overheat_clear, supply_low, step, code} = '0;
		repeat (16) @(posedge clock);
		#1 reset_n = 1'b1;
		cyc(5);
		t_pwm();
		t_step();
		t_sleep();
		t_fault();
		t_protect();
		summarize();
	end
endmodule : dbm_top_tb_top
